// [dmats_asserts.sv]
// Concurrent checks on the link between the two sequencer ends
`timescale 1ns/100ps
`default_nettype none
module dmats_asserts (
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  input wire logic [3:0] dma_ack,
  input wire logic hold_request,
  input wire logic hold_ack,
  input wire logic address_enable,
  input wire logic high_addr_latch_strobe,
  input wire logic eop_dev_oe_n,
  input wire logic mem_read_strobe,
  input wire logic mem_write_strobe,
  input wire logic io_read_strobe,
  input wire logic io_write_strobe
);
  // Any strobe at all, cascade and idle must keep this low
  logic any_stb;
  assign any_stb = mem_read_strobe | mem_write_strobe |
                   io_read_strobe | io_write_strobe;
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  // -----------------------------------------------------------
  // Link rules
  // -----------------------------------------------------------
  one_ack_a: assert property ($onehot0(dma_ack))
    else $error("two acknowledges at once");
  ack_bus_a: assert property (|dma_ack |-> hold_request && hold_ack)
    else $error("acknowledge without the bus");
  no_switch_a: assert property (|dma_ack && |$past(dma_ack) |->
    dma_ack == $past(dma_ack)) else $error("service switched channel");
  stb_aen_a: assert property (any_stb |-> address_enable)
    else $error("strobe without address enable");
  wr_pair_a: assert property (mem_write_strobe && |dma_ack |->
    io_read_strobe) else $error("memory write without I/O read");
  rd_pair_a: assert property (io_write_strobe |-> mem_read_strobe)
    else $error("I/O write without memory read");
  latch_a: assert property (high_addr_latch_strobe |->
    address_enable ##1 !high_addr_latch_strobe) else $error("latch strobe");
  eop_a: assert property (!eop_dev_oe_n |->
    address_enable ##1 eop_dev_oe_n) else $error("end pulse too long");
  // Main scenarios reached
  cover property (|dma_ack && mem_write_strobe);
  cover property (high_addr_latch_strobe);
  cover property (!eop_dev_oe_n && dma_ack == 4'h0);
endmodule // dmats_asserts
`default_nettype wire

// [dmats_device.sv]
// Four-channel DMA service sequencer with APB register access
// Summary of operation
// - Demand service runs until end, pauses on request drop
// - Current address and count readable while paused
// - After demand auto-init, restart needs a new request edge
// - Cascade channel only acknowledges, drives nothing else
// - Cascaded slave waits for acknowledge before bus use
// - Write: memory write plus I/O read; read reverse
// - Verify counts and addresses but keeps strobes off
// - Command bit 0 pairs channels 0 and 1
// - Pair starts on channel 0 software request
// - Software request ignores mask; channel 1 count ends the pair
// - Pair move enables address, keeps acknowledges off
// - External end of process stops a pair move
// - Mode bit 4 reloads current from base
// - Current write also writes base; base held
// - Auto-init channel keeps its mask bit clear
// - Fixed priority: channel 0 highest, 3 lowest
// - Rotating: served channel drops to lowest
// - Arbitration at each rising bus grant edge
// - No preemption; bus returns before next channel
// - Compressed timing skips S3, not for pairs
// - S1 puts high byte out for external latch
// - S1 on first transfer, high address byte change, and every pair step
// - Terminal count when count wraps 0000H to FFFFH
// - End sets status, clears request, masks non-auto
`timescale 1ns/100ps
`default_nettype none
module dmats_device
  import dmats_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  dmats_link_if.dev LINK,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // One-hot of a channel number
  function automatic logic [3:0] onehot(input logic [1:0] c);
    onehot = 4'h1 << c;
  endfunction

  // First requesting channel counting up from the top-priority slot
  function automatic logic [2:0] pick(input logic [3:0] p,
                                      input logic [1:0] base);
    logic [1:0] idx;
    pick = 3'h0;
    for (int k = 3; k >= 0; k--) begin
      idx = base + 2'(k);
      if (p[idx]) begin
        pick = {1'b1, idx};
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dmats_state_t st; // Sequencer state
  logic [7:0] cmd; // Command register
  logic [7:0] mode [NCH]; // Mode per channel
  logic [15:0] cur_a [NCH]; // Current address
  logic [15:0] cur_c [NCH]; // Current word count
  logic [15:0] base_a [NCH]; // Base address
  logic [15:0] base_c [NCH]; // Base word count
  logic [3:0] mask; // Request mask
  logic [3:0] sreq; // Software requests
  logic [3:0] tcst; // Sticky terminal count status
  logic [3:0] rearm; // Waiting for request to fall first
  logic [1:0] ch; // Channel in service
  logic [1:0] prio; // Top-priority slot for rotation
  logic m2m_act; // Memory-to-memory move in progress
  logic m2m_wr; // Write half of a move
  logic hold_ack_q; // Previous grant level
  logic [7:0] temp; // Word held between move halves
  // ----------------------------------------------------------------
  // Combinational terms
  // ----------------------------------------------------------------
  logic [3:0] pend; // Requests competing for the bus
  logic [2:0] sel; // Arbitration result {valid, channel}
  logic [1:0] ach; // Channel whose address is on the bus
  logic [1:0] cch; // Channel whose count is used
  logic [15:0] a_now; // Address of this transfer
  logic [15:0] a_nx; // Address of the next transfer
  logic [1:0] xf; // Transfer format of the served channel
  logic svc; // In S1..S4
  logic upd; // Transfer completes this cycle
  logic cnt_upd; // Count steps this cycle
  logic tc_now; // Count wraps this cycle
  logic ext_eop; // Far end pulls end of process
  logic xfer_end; // Service ends this cycle
  logic pause; // Demand request dropped
  logic [3:0] end_vec; // Channels ending service
  logic rd_win; // Read strobe window
  logic wr_hit, rd_stat, wr_ch; // APB decodes

  // Only channel 0 software request starts a pair; peripheral
  // requests on the pair are ignored
  always_comb begin
    pend = sreq | (LINK.dma_request & ~mask & ~rearm);
    if (cmd[CMD_M2M_BIT]) begin
      pend[0] = sreq[0];
      pend[1] = 1'b0;
    end
  end

  assign sel = pick(pend, cmd[CMD_ROT_BIT] ? prio : 2'h0);
  assign ach = m2m_act ? {1'b0, m2m_wr} : ch;
  assign cch = m2m_act ? 2'h1 : ch;
  assign a_now = cur_a[ach];
  assign a_nx = mode[ach][MODE_DEC_BIT] ? a_now - WC_STEP : a_now + WC_STEP;
  assign xf = mode[ch][MODE_XF_LSB +: 2];
  assign svc = (st == ST_S1) || (st == ST_S2) || (st == ST_S3) ||
               (st == ST_S4);
  assign upd = (st == ST_S4);
  assign cnt_upd = upd && (!m2m_act || m2m_wr);
  assign tc_now = cnt_upd && (cur_c[cch] == WC_TERM);
  assign ext_eop = upd && !LINK.end_of_process_n && LINK.eop_dev_oe_n;
  assign xfer_end = tc_now || ext_eop;
  assign pause = upd && !m2m_act && !LINK.dma_request[ch] &&
                 (mode[ch][MODE_MD_LSB +: 2] == MD_DEMAND);
  assign end_vec = !xfer_end ? 4'h0 : (m2m_act ? 4'h3 : onehot(ch));
  assign rd_win = (st == ST_S3) || (st == ST_S4);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Grant edge detector and service state machine
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      st <= ST_IDLE;
      hold_ack_q <= 1'b0;
    end else begin
      hold_ack_q <= LINK.hold_ack;
      case (st)
        ST_IDLE: begin
          if (|pend) begin
            st <= ST_S0;
          end
        end
        ST_S0: begin
          // Channel chosen only on a fresh grant edge
          if (LINK.hold_ack && !hold_ack_q) begin
            if (!sel[2]) begin
              st <= ST_REL;
            end else if (mode[sel[1:0]][MODE_MD_LSB +: 2] == MD_CASCADE &&
                         !(cmd[CMD_M2M_BIT] && sel[1:0] == 2'h0)) begin
              st <= ST_CASC;
            end else begin
              st <= ST_S1;
            end
          end
        end
        ST_S1: st <= ST_S2;
        ST_S2: begin
          // Pair moves need the longer read pulse
          if (cmd[CMD_COMP_BIT] && !m2m_act) begin
            st <= ST_S4;
          end else begin
            st <= ST_S3;
          end
        end
        ST_S3: st <= ST_S4;
        ST_S4: begin
          if (xfer_end || pause) begin
            st <= ST_REL;
          end else if (m2m_act || a_nx[15:8] != a_now[15:8]) begin
            st <= ST_S1;
          end else begin
            st <= ST_S2;
          end
        end
        ST_CASC: begin
          if (!LINK.dma_request[ch]) begin
            st <= ST_REL;
          end
        end
        ST_REL: begin
          // Wait for grant to fall so the next service sees an edge
          if (!LINK.hold_ack) begin
            st <= ST_IDLE;
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  // Channel capture, rotation and move phase
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      ch <= 2'h0;
      prio <= 2'h0;
      m2m_act <= 1'b0;
      m2m_wr <= 1'b0;
    end else if (st == ST_S0 && LINK.hold_ack && !hold_ack_q && sel[2]) begin
      ch <= sel[1:0];
      prio <= sel[1:0] + 2'h1;
      m2m_act <= cmd[CMD_M2M_BIT] && sel[1:0] == 2'h0;
      m2m_wr <= 1'b0;
    end else if (upd && m2m_act) begin
      m2m_wr <= !m2m_wr;
    end
  end

  // Read half of a move parks the word for the write half
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      temp <= 8'h00;
    end else if (upd && m2m_act && !m2m_wr) begin
      temp <= LINK.db_in;
    end
  end

  // ----------------------------------------------------------------
  // Address and count registers
  // ----------------------------------------------------------------
  assign wr_hit = PSEL_IN && PENABLE_IN && PWRITE_IN;
  assign wr_ch = wr_hit && PADDR_IN < OFS_CMD && PADDR_IN[1:0] == 2'h0;

  // Stepping, auto reload and software load share one process
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      for (int i = 0; i < NCH; i++) begin
        cur_a[i] <= 16'h0000;
        cur_c[i] <= 16'h0000;
        base_a[i] <= 16'h0000;
        base_c[i] <= 16'h0000;
      end
    end else begin
      if (upd) begin
        cur_a[ach] <= a_nx;
      end
      if (cnt_upd) begin
        cur_c[cch] <= cur_c[cch] - WC_STEP;
      end
      for (int i = 0; i < NCH; i++) begin
        if (end_vec[i] && mode[i][MODE_AUTO_BIT]) begin
          cur_a[i] <= base_a[i];
          cur_c[i] <= base_c[i];
        end
      end
      if (wr_ch) begin
        if (PADDR_IN[2]) begin
          cur_c[PADDR_IN[4:3]] <= PWDATA_IN[15:0];
          base_c[PADDR_IN[4:3]] <= PWDATA_IN[15:0];
        end else begin
          cur_a[PADDR_IN[4:3]] <= PWDATA_IN[15:0];
          base_a[PADDR_IN[4:3]] <= PWDATA_IN[15:0];
        end
      end
    end
  end

  // Command and mode registers
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      cmd <= CMD_RST;
      for (int i = 0; i < NCH; i++) begin
        mode[i] <= MODE_RST;
      end
    end else if (wr_hit) begin
      if (PADDR_IN == OFS_CMD) begin
        cmd <= PWDATA_IN[7:0];
      end else if (PADDR_IN[7:4] == OFS_MODE[7:4] &&
                   PADDR_IN[1:0] == 2'h0) begin
        mode[PADDR_IN[3:2]] <= PWDATA_IN[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Mask, request, status and re-arm bits
  // ----------------------------------------------------------------
  assign rd_stat = PSEL_IN && PENABLE_IN && !PWRITE_IN &&
                   PADDR_IN == OFS_STATUS;

  // Hardware set wins over a clear-on-read in the same cycle
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      mask <= MASK_RST;
      sreq <= 4'h0;
      tcst <= 4'h0;
      rearm <= 4'h0;
    end else begin
      if (wr_hit && PADDR_IN == OFS_MASK) begin
        mask <= PWDATA_IN[3:0];
      end
      if (wr_hit && PADDR_IN == OFS_REQ) begin
        sreq <= PWDATA_IN[3:0];
      end
      for (int i = 0; i < NCH; i++) begin
        if (LINK.dma_request[i] == 1'b0) begin
          rearm[i] <= 1'b0;
        end
        if (end_vec[i]) begin
          sreq[i] <= 1'b0;
          if (!mode[i][MODE_AUTO_BIT]) begin
            mask[i] <= 1'b1;
          end else if (mode[i][MODE_MD_LSB +: 2] == MD_DEMAND) begin
            rearm[i] <= 1'b1;
          end
        end
      end
      tcst <= (rd_stat ? 4'h0 : tcst) | end_vec;
    end
  end

  // ----------------------------------------------------------------
  // Link outputs
  // ----------------------------------------------------------------
  assign LINK.hold_request = (st != ST_IDLE) && (st != ST_REL);
  assign LINK.dma_ack = ((svc && !m2m_act) || st == ST_CASC) ?
                        onehot(ch) : 4'h0;
  assign LINK.address_enable = svc;
  assign LINK.high_addr_latch_strobe = (st == ST_S1);
  assign LINK.addr_low = svc ? a_now[7:0] : 8'h00;
  assign LINK.db_out = (st == ST_S1) ? a_now[15:8] :
                       (svc && m2m_wr) ? temp : 8'h00;
  // Verify format leaves every strobe idle
  assign LINK.mem_read_strobe = rd_win && (m2m_act ? !m2m_wr :
                                xf == XF_READ);
  assign LINK.mem_write_strobe = upd && (m2m_act ? m2m_wr :
                                 xf == XF_WRITE);
  assign LINK.io_read_strobe = rd_win && !m2m_act && xf == XF_WRITE;
  assign LINK.io_write_strobe = upd && !m2m_act && xf == XF_READ;
  assign LINK.eop_dev_out = 1'b0; // Open drain only pulls low
  assign LINK.eop_dev_oe_n = !tc_now;

  // ----------------------------------------------------------------
  // APB slave: zero wait, data registered in the setup cycle
  // ----------------------------------------------------------------
  logic [31:0] rd_mux; // Read data for the addressed register
  logic hit; // Address is mapped

  assign hit = PADDR_IN[1:0] == 2'h0 &&
               (PADDR_IN <= OFS_MASK ||
                (PADDR_IN >= OFS_MODE && PADDR_IN <= OFS_STATUS));

  // Current values stay readable between demand bursts
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (!hit) begin
      rd_mux = 32'h0000_0000;
    end else if (PADDR_IN < OFS_CMD) begin
      rd_mux[15:0] = PADDR_IN[2] ? cur_c[PADDR_IN[4:3]] :
                     cur_a[PADDR_IN[4:3]];
    end else if (PADDR_IN == OFS_CMD) begin
      rd_mux[7:0] = cmd;
    end else if (PADDR_IN == OFS_REQ) begin
      rd_mux[3:0] = sreq;
    end else if (PADDR_IN == OFS_MASK) begin
      rd_mux[3:0] = mask;
    end else if (PADDR_IN == OFS_STATUS) begin
      rd_mux[7:0] = {pend, tcst};
    end else begin
      rd_mux[7:0] = mode[PADDR_IN[3:2]];
    end
  end

  // Capture read data in the setup cycle
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      PRDATA_OUT <= 32'h0000_0000;
    end else if (PSEL_IN && !PENABLE_IN) begin
      PRDATA_OUT <= rd_mux;
    end
  end

  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !hit;
endmodule // dmats_device
`default_nettype wire

// [dmats_host.sv]
// Bus owner and peripheral end of the DMA link
`timescale 1ns/100ps
`default_nettype none
module dmats_host
  import dmats_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  dmats_link_if.host LINK,
  input wire logic [3:0] DMA_REQUEST_IN_IN,
  input wire logic EOP_REQ_IN,
  input wire logic [7:0] MEM_DATA_IN,
  output logic [3:0] DMA_ACK_OUT_OUT,
  output logic BUS_GRANT_OUT,
  output logic [15:0] ADDR_OUT,
  output logic EOP_SEEN_OUT
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] dma_request_in_m, dma_request_in_s; // Request synchroniser stages
  logic eop_m, eop_s; // End request synchroniser stages
  logic [7:0] hi_latch; // External high address latch

  // Two stages before any logic looks at a request or end pin
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      dma_request_in_m <= 4'h0;
      dma_request_in_s <= 4'h0;
      eop_m <= 1'b0;
      eop_s <= 1'b0;
    end else begin
      dma_request_in_m <= DMA_REQUEST_IN_IN;
      dma_request_in_s <= dma_request_in_m;
      eop_m <= EOP_REQ_IN;
      eop_s <= eop_m;
    end
  end

  // ----------------------------------------------------------------
  // Bus hand-over and link drive
  // ----------------------------------------------------------------
  // Grant follows the request one cycle later; a cascaded slave on a
  // request line only sees its grant through the acknowledge
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      LINK.hold_ack <= 1'b0;
      LINK.dma_request <= 4'h0;
      LINK.eop_host_oe_n <= 1'b1;
      LINK.db_in <= 8'h00;
    end else begin
      LINK.hold_ack <= LINK.hold_request;
      LINK.dma_request <= dma_request_in_s;
      LINK.eop_host_oe_n <= !eop_s;
      LINK.db_in <= MEM_DATA_IN;
    end
  end
  assign LINK.eop_host_out = 1'b0; // Open drain only pulls low

  // ----------------------------------------------------------------
  // User side
  // ----------------------------------------------------------------
  // The edge that ends the strobe is its trailing edge; one cycle
  // later the data lines no longer carry the high byte
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      hi_latch <= 8'h00;
    end else if (LINK.high_addr_latch_strobe) begin
      hi_latch <= LINK.db_out;
    end
  end

  // Acknowledge returned to the requester or cascaded slave
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      DMA_ACK_OUT_OUT <= 4'h0;
      BUS_GRANT_OUT <= 1'b0;
      ADDR_OUT <= 16'h0000;
      EOP_SEEN_OUT <= 1'b0;
    end else begin
      DMA_ACK_OUT_OUT <= LINK.dma_ack;
      BUS_GRANT_OUT <= LINK.hold_ack;
      ADDR_OUT <= LINK.address_enable ? {hi_latch, LINK.addr_low} : 16'h0000;
      EOP_SEEN_OUT <= !LINK.end_of_process_n;
    end
  end
endmodule // dmats_host
`default_nettype wire

// [dmats_link_if.sv]
// Link between the DMA sequencer and the bus owner / peripheral end
`timescale 1ns/100ps
`default_nettype none
interface dmats_link_if;
  logic [3:0] dma_request; // Peripheral or cascade requests, high active
  logic [3:0] dma_ack; // Channel acknowledges, high active
  logic hold_request; // Bus wanted by the sequencer
  logic hold_ack; // Bus granted by the processor side
  logic eop_dev_out; // Open-drain data, sequencer
  logic eop_dev_oe_n; // Low while sequencer pulls the line
  logic eop_host_out; // Open-drain data, far end
  logic eop_host_oe_n; // Low while far end pulls the line
  logic end_of_process_n; // Resolved line, pulled up when idle
  logic [7:0] addr_low; // Low address byte
  logic [7:0] db_out; // High address byte or memory write data
  logic [7:0] db_in; // Memory read data for block moves
  logic high_addr_latch_strobe; // Latch captures on falling edge
  logic address_enable; // Enables the external high byte latch
  logic mem_read_strobe;
  logic mem_write_strobe;
  logic io_read_strobe;
  logic io_write_strobe;
  // Wired-AND of both open-drain drivers
  assign end_of_process_n = !((!eop_dev_oe_n && !eop_dev_out) ||
                              (!eop_host_oe_n && !eop_host_out));
  modport dev (
    input dma_request, hold_ack, end_of_process_n, db_in,
    output dma_ack, hold_request, eop_dev_out, eop_dev_oe_n, addr_low,
    output db_out, high_addr_latch_strobe, address_enable,
    output mem_read_strobe, mem_write_strobe, io_read_strobe,
    output io_write_strobe
  );
  modport host (
    output dma_request, hold_ack, eop_host_out, eop_host_oe_n, db_in,
    input dma_ack, hold_request, end_of_process_n, addr_low, db_out,
    input high_addr_latch_strobe, address_enable, mem_read_strobe,
    input mem_write_strobe, io_read_strobe, io_write_strobe
  );
endinterface
`default_nettype wire

// [dmats_pkg.sv]
// Shared constants, register map and state type of the DMA sequencer
package dmats_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NCH = 4; // Number of channels
  // ----------------------------------------------------------------
  // Register offsets (byte addresses on APB)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CH_BASE = 8'h00; // Per channel: +0 addr, +4 count
  localparam logic [7:0] OFS_CMD = 8'h20; // Command register
  localparam logic [7:0] OFS_REQ = 8'h24; // Software request bits
  localparam logic [7:0] OFS_MASK = 8'h28; // Request mask bits
  localparam logic [7:0] OFS_MODE = 8'h30; // Mode of channel n at +4*n
  localparam logic [7:0] OFS_STATUS = 8'h40; // Status, clears on read
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CMD_M2M_BIT = 0; // Channel 0/1 memory-to-memory pair
  localparam int CMD_COMP_BIT = 3; // Compressed two-cycle timing
  localparam int CMD_ROT_BIT = 4; // Rotating priority
  localparam int MODE_XF_LSB = 2; // Transfer format field [3:2]
  localparam int MODE_AUTO_BIT = 4; // Auto-initialization
  localparam int MODE_DEC_BIT = 5; // Address decrement
  localparam int MODE_MD_LSB = 6; // Service mode field [7:6]
  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] XF_VERIFY = 2'h0; // Pseudo transfer
  localparam logic [1:0] XF_WRITE = 2'h1; // I/O to memory
  localparam logic [1:0] XF_READ = 2'h2; // Memory to I/O
  localparam logic [1:0] MD_DEMAND = 2'h0; // Demand service
  localparam logic [1:0] MD_CASCADE = 2'h3; // Cascade arbitration only
  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_RST = 8'h00; // Fixed priority, normal timing
  localparam logic [7:0] MODE_RST = 8'h00; // Demand, verify
  localparam logic [3:0] MASK_RST = 4'hF; // All channels masked
  localparam logic [15:0] WC_TERM = 16'h0000; // Count that wraps to FFFFH
  localparam logic [15:0] WC_STEP = 16'h0001; // Step of address and count
  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_S0, ST_S1, ST_S2, ST_S3, ST_S4, ST_CASC, ST_REL
  } dmats_state_t;
endpackage

// [test_dma_transfer_mode_sequencer.sv]
// Self-checking bench joining both ends of the DMA sequencer
`timescale 1ns/100ps
`default_nettype none
module test_dma_transfer_mode_sequencer;
  import dmats_pkg::*;
  // -----------------------------------------------------------
  // Stimulus, instances and checks
  // -----------------------------------------------------------
  logic clk, rn, ps, pe, pw, rdy, err, grant, seen, eopr, hit;
  logic [7:0] pa, md;
  logic [31:0] wd, rdat;
  logic [3:0] dma_request_in, dma_ack_out;
  logic [15:0] a, n, ao;
  logic [32:0] exp_q[$]; // Expected {error, read data}, oldest first
  int n_errors, n_tests, cyc, seed, f;
  dmats_link_if dmats_link_if_inst();
  dmats_device dmats_device_inst(.CLK_IN(clk), .RESETN_IN(rn),
    .LINK(dmats_link_if_inst), .PSEL_IN(ps), .PENABLE_IN(pe),
    .PWRITE_IN(pw), .PADDR_IN(pa), .PWDATA_IN(wd), .PRDATA_OUT(rdat),
    .PREADY_OUT(rdy), .PSLVERR_OUT(err));
  dmats_host dmats_host_inst(.CLK_IN(clk), .RESETN_IN(rn),
    .LINK(dmats_link_if_inst), .DMA_REQUEST_IN_IN(dma_request_in), .EOP_REQ_IN(eopr),
    .MEM_DATA_IN(md), .DMA_ACK_OUT_OUT(dma_ack_out), .BUS_GRANT_OUT(grant),
    .ADDR_OUT(ao), .EOP_SEEN_OUT(seen));
  dmats_asserts dmats_asserts_inst(.CLK_IN(clk), .RESETN_IN(rn),
    .dma_ack(dmats_link_if_inst.dma_ack),
    .hold_request(dmats_link_if_inst.hold_request),
    .hold_ack(dmats_link_if_inst.hold_ack),
    .address_enable(dmats_link_if_inst.address_enable),
    .high_addr_latch_strobe(dmats_link_if_inst.high_addr_latch_strobe),
    .eop_dev_oe_n(dmats_link_if_inst.eop_dev_oe_n),
    .mem_read_strobe(dmats_link_if_inst.mem_read_strobe),
    .mem_write_strobe(dmats_link_if_inst.mem_write_strobe),
    .io_read_strobe(dmats_link_if_inst.io_read_strobe),
    .io_write_strobe(dmats_link_if_inst.io_write_strobe));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One APB transfer; waits on ready, never assumes a latency
  task automatic bus(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    @(posedge clk);
    {ps, pe, pw, pa, wd} <= {2'b10, w, ad, d};
    @(posedge clk);
    pe <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    {ps, pe} <= 2'b00;
  endtask
  task automatic rd(input logic [7:0] ad, input logic e,
                    input logic [15:0] v);
    exp_q.push_back({e, 16'h0, v});
    bus(1'b0, ad, 32'h0);
  endtask
  // Wait for the end pulse, then for the bus to come back
  task automatic run;
    hit = 1'b0;
    repeat (400) begin
      @(posedge clk);
      if (seen === 1'b1) hit = 1'b1;
      if (hit) break;
    end
    chk({32'h0, hit}, 33'h1);
    while (grant !== 1'b0) @(posedge clk);
    repeat (6) @(posedge clk);
  endtask
  // Read checker and hang guard
  always @(posedge clk) begin
    cyc++;
    if (ps && pe && !pw && rdy) chk({err, rdat}, exp_q.pop_front());
    if (cyc > 30000) begin
      n_errors++;
      test_done();
    end
  end
  initial begin
    seed = 32'h8A80;
    {rn, ps, pe, pw, pa, wd, dma_request_in, eopr, md} = '0;
    repeat (16) @(posedge clk);
    rn <= 1'b1;
    rd(OFS_MASK, 1'b0, {12'h0, MASK_RST});
    rd(8'h2C, 1'b1, 16'h0);
    // Verify, write and read formats with timing variants
    for (f = 0; f < 3; f++) begin
      a = 16'($random(seed));
      n = 16'($random(seed) & 3);
      bus(1'b1, OFS_CMD, 32'(f << CMD_COMP_BIT));
      bus(1'b1, 8'(8 * f), {16'h0, a});
      bus(1'b1, 8'(8 * f + 4), {16'h0, n});
      bus(1'b1, 8'(OFS_MODE + 4 * f),
          32'((f << MODE_XF_LSB) | (f / 2 << MODE_DEC_BIT)));
      bus(1'b1, OFS_MASK, 32'(4'hF & ~(1 << f)));
      rd(8'(8 * f + 4), 1'b0, n);
      dma_request_in[f] <= 1'b1;
      md <= 8'($random(seed));
      wait (dma_ack_out[f]);
      repeat (2) @(posedge clk);
      chk({17'h0, ao}, {17'h0, a});
      run();
      dma_request_in <= 4'h0;
      rd(8'(8 * f), 1'b0, 16'(f == 2 ? a - n - 1 : a + n + 1));
      rd(8'(8 * f + 4), 1'b0, 16'hFFFF);
      rd(OFS_STATUS, 1'b0, 16'(1 << f));
      rd(OFS_MASK, 1'b0, 16'hF);
    end
    // Fixed priority, then auto-init on the lower-priority channel 3
    bus(1'b1, OFS_CMD, 32'h0);
    bus(1'b1, 8'h0C, 32'h0);
    bus(1'b1, 8'h1C, 32'h1);
    bus(1'b1, 8'h34, 32'h0);
    bus(1'b1, 8'h3C, 32'h14);
    bus(1'b1, OFS_MASK, 32'h5);
    dma_request_in <= 4'hA;
    repeat (100) begin
      @(posedge clk);
      if (dma_ack_out !== 4'h0) break;
    end
    chk({29'h0, dma_ack_out}, 33'h2);
    run();
    dma_request_in[1] <= 1'b0;
    run();
    rd(8'h1C, 1'b0, 16'h1);
    rd(OFS_MASK, 1'b0, 16'h7);
    repeat (40) @(posedge clk);
    chk({32'h0, grant}, 33'h0);
    dma_request_in <= 4'h0;
    rd(OFS_STATUS, 1'b0, 16'hA);
    // Memory block move cut short by an external end
    bus(1'b1, OFS_CMD, 32'h1);
    bus(1'b1, 8'h04, 32'hFF);
    bus(1'b1, 8'h0C, 32'hFF);
    bus(1'b1, OFS_REQ, 32'h1);
    repeat (60) @(posedge clk);
    chk({29'h0, dma_ack_out}, 33'h0);
    eopr <= 1'b1;
    run();
    eopr <= 1'b0;
    chk({32'h0, hit}, 33'h1);
    rd(OFS_STATUS, 1'b0, 16'h3);
    test_done();
  end
endmodule // test_dma_transfer_mode_sequencer
`default_nettype wire
